// *** hdl/cpu_core_params.svh ***
// Constants for the processor core: bus map, reset values, flags and opcodes
`ifndef CPU_CORE_PARAMS_SVH
`define CPU_CORE_PARAMS_SVH

// ==========================================
// APB register map
`define ADDR_CTRL 12'h000
`define ADDR_REGS 12'h004
`define ADDR_PTRS 12'h008
`define CTRL_RUN_BIT 0
`define CTRL_CLR_BIT 1
`define CTRL_RUN_RESET 1'b1

// ==========================================
// Reset values and fixed pages
`define RESET_PC_VALUE 16'h0000
`define RESET_SP 8'hff
`define RESET_P 8'h20
`define RESET_BYTE 8'h00
`define STACK_PAGE 8'h01
`define ZERO_PAGE 8'h00
`define PUSH_STATUS_SET 8'h30

// ==========================================
// Status flag bit positions
`define FLAG_N 7
`define FLAG_Z 1
`define FLAG_C 0

// ==========================================
// Opcodes
`define INC_X 8'he8
`define INC_Y 8'hc8
`define JUMP_ABS 8'h4c
`define JUMP_IND 8'h6c
`define CALL_ABS 8'h20
`define LD_A_IMM 8'ha9
`define LD_A_ZP 8'ha5
`define LD_A_ZPX 8'hb5
`define LD_A_ABS 8'had
`define LD_A_ABX 8'hbd
`define LD_A_ABY 8'hb9
`define LD_A_INX 8'ha1
`define LD_A_INY 8'hb1
`define LD_X_IMM 8'ha2
`define LD_X_ZP 8'ha6
`define LD_X_ZPY 8'hb6
`define LD_X_ABS 8'hae
`define LD_X_ABY 8'hbe
`define LD_Y_IMM 8'ha0
`define LD_Y_ZP 8'ha4
`define LD_Y_ZPX 8'hb4
`define LD_Y_ABS 8'hac
`define LD_Y_ABX 8'hbc
`define SHR_ACC 8'h4a
`define SHR_ZP 8'h46
`define SHR_ZPX 8'h56
`define SHR_ABS 8'h4e
`define SHR_ABX 8'h5e
`define IDLE 8'hea
`define OR_A_IMM 8'h09
`define OR_A_ZP 8'h05
`define OR_A_ZPX 8'h15
`define OR_A_ABS 8'h0d
`define OR_A_ABX 8'h1d
`define OR_A_ABY 8'h19
`define OR_A_INX 8'h01
`define OR_A_INY 8'h11
`define PUSH_A 8'h48
`define PUSH_P 8'h08
`define PULL_A 8'h68
`define PULL_P 8'h28
`define ROT_ACC 8'h2a
`define ROT_ZP 8'h26
`define ROT_ZPX 8'h36
`define ROT_ABS 8'h2e
`define ROT_ABX 8'h3e

`endif

// *** hdl/cpu_core_pkg.sv ***
// Types shared by the processor core and its opcode decoder
package cpu_core_pkg;

  // ==========================================
  // Operation classes
  typedef enum {
    idle_op, increment_index_x_op, increment_index_y_op, jump_op, call_subroutine_op,
    load_accumulator_op, load_index_x_op, load_index_y_op, shift_right_op, or_accumulator_op,
    push_accumulator_op, push_status_op, pull_accumulator_op, pull_status_op, rotate_left_op
  } op_t;

  // ==========================================
  // Addressing modes
  typedef enum {
    am_imp, am_acc, am_imm, am_zp, am_zpx, am_zpy, am_abs, am_absx, am_absy,
    am_indx, am_indy, am_jabs, am_jind, am_jsr, am_push, am_pull
  } amode_t;

  // ==========================================
  // Bus cycle states
  typedef enum {
    st_fetch, st_op1, st_op2, st_zidx, st_plo, st_phi, st_fix, st_read,
    st_rmw_rd, st_rmw_dw, st_rmw_wr, st_push, st_pinc, st_pull,
    st_jstk, st_jpch, st_jpcl, st_jhi
  } state_t;

endpackage

// *** hdl/opcode_decoder.sv ***
// Opcode decoder: maps an opcode byte to operation and addressing mode
`include "cpu_core_params.svh"

module opcode_decoder (
  // Opcode in
  input wire logic [7:0] opcode,
  // Decoded result
  output cpu_core_pkg::op_t op,
  output cpu_core_pkg::amode_t mode,
  output logic illegal
);
  import cpu_core_pkg::*;

  // ==========================================
  // Operation class; unknown codes run as a two-cycle idle
  always_comb begin
    op = idle_op;
    illegal = 1'b0;
    unique case (opcode)
      `INC_X: op = increment_index_x_op;
      `INC_Y: op = increment_index_y_op;
      `JUMP_ABS, `JUMP_IND: op = jump_op;
      `CALL_ABS: op = call_subroutine_op;
      `LD_A_IMM, `LD_A_ZP, `LD_A_ZPX, `LD_A_ABS, `LD_A_ABX, `LD_A_ABY, `LD_A_INX, `LD_A_INY:
        op = load_accumulator_op;
      `LD_X_IMM, `LD_X_ZP, `LD_X_ZPY, `LD_X_ABS, `LD_X_ABY: op = load_index_x_op;
      `LD_Y_IMM, `LD_Y_ZP, `LD_Y_ZPX, `LD_Y_ABS, `LD_Y_ABX: op = load_index_y_op;
      `SHR_ACC, `SHR_ZP, `SHR_ZPX, `SHR_ABS, `SHR_ABX: op = shift_right_op;
      `ROT_ACC, `ROT_ZP, `ROT_ZPX, `ROT_ABS, `ROT_ABX: op = rotate_left_op;
      `OR_A_IMM, `OR_A_ZP, `OR_A_ZPX, `OR_A_ABS, `OR_A_ABX, `OR_A_ABY, `OR_A_INX, `OR_A_INY:
        op = or_accumulator_op;
      `IDLE: op = idle_op;
      `PUSH_A: op = push_accumulator_op;
      `PUSH_P: op = push_status_op;
      `PULL_A: op = pull_accumulator_op;
      `PULL_P: op = pull_status_op;
      default: illegal = 1'b1;
    endcase
  end

  // ==========================================
  // Addressing mode; implied covers idle and unknown codes
  always_comb begin
    mode = am_imp;
    unique case (opcode)
      `LD_A_IMM, `LD_X_IMM, `LD_Y_IMM, `OR_A_IMM: mode = am_imm;
      `LD_A_ZP, `LD_X_ZP, `LD_Y_ZP, `OR_A_ZP, `SHR_ZP, `ROT_ZP: mode = am_zp;
      `LD_A_ZPX, `LD_Y_ZPX, `OR_A_ZPX, `SHR_ZPX, `ROT_ZPX: mode = am_zpx;
      `LD_X_ZPY: mode = am_zpy;
      `LD_A_ABS, `LD_X_ABS, `LD_Y_ABS, `OR_A_ABS, `SHR_ABS, `ROT_ABS: mode = am_abs;
      `LD_A_ABX, `LD_Y_ABX, `OR_A_ABX, `SHR_ABX, `ROT_ABX: mode = am_absx;
      `LD_A_ABY, `LD_X_ABY, `OR_A_ABY: mode = am_absy;
      `LD_A_INX, `OR_A_INX: mode = am_indx;
      `LD_A_INY, `OR_A_INY: mode = am_indy;
      `SHR_ACC, `ROT_ACC: mode = am_acc;
      `JUMP_ABS: mode = am_jabs;
      `JUMP_IND: mode = am_jind;
      `CALL_ABS: mode = am_jsr;
      `PUSH_A, `PUSH_P: mode = am_push;
      `PULL_A, `PULL_P: mode = am_pull;
      default: mode = am_imp;
    endcase
  end

endmodule

// *** hdl/cpu_core.sv ***
// Eight-bit processor core subset with APB run control and state readback
// How it works
// - E8/C8 increment X/Y, set N and Z
// - Jumps 4C/6C load PC, flags untouched
// - Call 20 pushes last-byte address, six cycles
// - Loads A/X/Y, immediate two cycles, N Z
// - Indexed accumulator loads add page-cross cycle
// - Indexed X/Y loads add page-cross cycle
// - OR memory into accumulator, set N Z
// - Shift right, zero in, bit0 to carry
// - Rotate left through carry, memory or accumulator
// - EA idles two cycles, only PC advances
// - 48 pushes accumulator in three cycles
// - 08 pushes status in three cycles
// - 68 pulls accumulator, sets N Z
// - 28 pulls status, replacing all flags
`include "cpu_core_params.svh"

module cpu_core #(
  parameter logic [15:0] RESET_PC = `RESET_PC_VALUE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Memory bus
  output logic [15:0] mem_addr,
  output logic mem_read,
  output logic mem_write,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import cpu_core_pkg::*;

  // ==========================================
  // Core state
  state_t state_reg, state_next; // Bus cycle within instruction
  op_t op_reg, op_next; // Current operation
  amode_t am_reg, am_next; // Current addressing mode
  logic [15:0] pc_reg, pc_next; // Program counter
  logic [15:0] ea_reg, ea_next; // Effective or pointer address
  logic [7:0] a_reg, a_next; // Accumulator
  logic [7:0] x_reg, x_next; // Index X
  logic [7:0] y_reg, y_next; // Index Y
  logic [7:0] sp_reg, sp_next; // Stack pointer
  logic [7:0] p_reg, p_next; // Status flags
  logic [7:0] tmp_reg, tmp_next; // Operand low byte or data held
  logic cross_reg, cross_next; // Index carried into high byte

  // ==========================================
  // APB state
  logic run_reg, run_next; // Core fetches when set
  logic bad_reg, bad_next; // Sticky unknown-opcode flag
  logic err_reg, err_next; // Slave error for the access phase
  logic [31:0] prdata_reg, prdata_next; // Read data captured at setup

  // ==========================================
  // Decode and datapath helpers
  op_t dec_op; // Decoded operation of fetched byte
  amode_t dec_am; // Decoded mode of fetched byte
  logic dec_bad; // Fetched byte is not handled
  logic [7:0] idx; // Index used by this mode
  logic [8:0] sum9; // Low byte plus index with carry
  logic rmw; // Memory read-modify-write operation
  state_t tgt; // State after the address is known
  logic [15:0] stack_addr; // Stack slot in page one
  logic [7:0] sh_src; // Shifter input
  logic [7:0] sh_res; // Shifter output
  logic sh_c; // Bit shifted out to carry
  logic [7:0] inc_x; // X plus one
  logic [7:0] inc_y; // Y plus one
  logic exec; // Finish a register operation this cycle
  logic bad_set; // Unknown opcode seen at fetch

  opcode_decoder u_dec (
    .opcode(mem_rdata),
    .op(dec_op),
    .mode(dec_am),
    .illegal(dec_bad)
  );

  // Zero-page Y, absolute Y and indirect-indexed use Y, the rest X
  assign idx = (am_reg == am_zpy || am_reg == am_absy || am_reg == am_indy) ? y_reg : x_reg;
  assign sum9 = {1'b0, tmp_reg} + {1'b0, idx};
  assign rmw = (op_reg == shift_right_op) || (op_reg == rotate_left_op);
  assign tgt = rmw ? st_rmw_rd : st_read;
  assign stack_addr = {`STACK_PAGE, sp_reg};
  assign sh_src = (state_reg == st_rmw_wr) ? tmp_reg : a_reg;
  // Rotate feeds old carry in at bit 0; shift feeds zero at bit 7
  assign sh_res = (op_reg == rotate_left_op) ? {sh_src[6:0], p_reg[`FLAG_C]} : {1'b0, sh_src[7:1]};
  assign sh_c = (op_reg == rotate_left_op) ? sh_src[7] : sh_src[0];
  assign inc_x = x_reg + 8'h01;
  assign inc_y = y_reg + 8'h01;
  assign bad_set = (state_reg == st_fetch) && run_reg && dec_bad;

  // Negative and zero flags from a result
  function automatic logic [7:0] nz(input logic [7:0] p, input logic [7:0] v);
    nz = p;
    nz[`FLAG_N] = v[7];
    nz[`FLAG_Z] = (v == 8'h00);
  endfunction

  // ==========================================
  // Core next state: one bus access per clock
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    am_next = am_reg;
    pc_next = pc_reg;
    ea_next = ea_reg;
    a_next = a_reg;
    x_next = x_reg;
    y_next = y_reg;
    sp_next = sp_reg;
    p_next = p_reg;
    tmp_next = tmp_reg;
    cross_next = cross_reg;
    mem_addr = pc_reg;
    mem_read = 1'b0;
    mem_write = 1'b0;
    mem_wdata = 8'h00;
    exec = 1'b0;
    unique case (state_reg)
      st_fetch: begin
        // Halt only between instructions, so none is left half done
        if (run_reg) begin
          mem_read = 1'b1;
          op_next = dec_op;
          am_next = dec_am;
          pc_next = pc_reg + 16'h0001;
          state_next = st_op1;
        end
      end
      st_op1: begin
        mem_read = 1'b1;
        unique case (am_reg)
          am_imp, am_acc: begin
            // Dummy read of next byte, PC stays
            exec = 1'b1;
            state_next = st_fetch;
          end
          am_push: state_next = st_push;
          am_pull: state_next = st_pinc;
          am_imm: begin
            pc_next = pc_reg + 16'h0001;
            exec = 1'b1;
            state_next = st_fetch;
          end
          am_zp: begin
            pc_next = pc_reg + 16'h0001;
            ea_next = {`ZERO_PAGE, mem_rdata};
            state_next = tgt;
          end
          am_zpx, am_zpy, am_indx: begin
            pc_next = pc_reg + 16'h0001;
            ea_next = {`ZERO_PAGE, mem_rdata};
            state_next = st_zidx;
          end
          am_indy: begin
            pc_next = pc_reg + 16'h0001;
            ea_next = {`ZERO_PAGE, mem_rdata};
            state_next = st_plo;
          end
          am_jsr: begin
            pc_next = pc_reg + 16'h0001;
            tmp_next = mem_rdata;
            state_next = st_jstk;
          end
          am_abs, am_absx, am_absy, am_jabs, am_jind: begin
            pc_next = pc_reg + 16'h0001;
            tmp_next = mem_rdata;
            state_next = st_op2;
          end
        endcase
      end
      st_zidx: begin
        // Index added to low byte only; carry is dropped
        mem_addr = ea_reg;
        mem_read = 1'b1;
        ea_next = {`ZERO_PAGE, ea_reg[7:0] + idx};
        state_next = (am_reg == am_indx) ? st_plo : tgt;
      end
      st_op2: begin
        mem_read = 1'b1;
        if (am_reg == am_jabs) begin
          pc_next = {mem_rdata, tmp_reg};
          state_next = st_fetch;
        end else begin
          pc_next = pc_reg + 16'h0001;
          if (am_reg == am_jind) begin
            ea_next = {mem_rdata, tmp_reg};
            state_next = st_plo;
          end else if (am_reg == am_abs) begin
            ea_next = {mem_rdata, tmp_reg};
            state_next = tgt;
          end else begin
            // Memory updates always take the fix cycle
            ea_next = {mem_rdata, sum9[7:0]};
            cross_next = sum9[8];
            state_next = (sum9[8] || rmw) ? st_fix : tgt;
          end
        end
      end
      st_plo: begin
        mem_addr = ea_reg;
        mem_read = 1'b1;
        tmp_next = mem_rdata;
        // Zero-page pointers wrap; the jump pointer does not
        ea_next = (am_reg == am_jind) ? ea_reg + 16'h0001 : {`ZERO_PAGE, ea_reg[7:0] + 8'h01};
        state_next = st_phi;
      end
      st_phi: begin
        mem_addr = ea_reg;
        mem_read = 1'b1;
        if (am_reg == am_jind) begin
          pc_next = {mem_rdata, tmp_reg};
          state_next = st_fetch;
        end else if (am_reg == am_indx) begin
          ea_next = {mem_rdata, tmp_reg};
          state_next = st_read;
        end else begin
          ea_next = {mem_rdata, sum9[7:0]};
          cross_next = sum9[8];
          state_next = sum9[8] ? st_fix : st_read;
        end
      end
      st_fix: begin
        // Dummy read at the uncorrected address
        mem_addr = ea_reg;
        mem_read = 1'b1;
        ea_next = {ea_reg[15:8] + {7'h00, cross_reg}, ea_reg[7:0]};
        state_next = tgt;
      end
      st_read: begin
        mem_addr = ea_reg;
        mem_read = 1'b1;
        exec = 1'b1;
        state_next = st_fetch;
      end
      st_rmw_rd: begin
        mem_addr = ea_reg;
        mem_read = 1'b1;
        tmp_next = mem_rdata;
        state_next = st_rmw_dw;
      end
      st_rmw_dw: begin
        // Old value written back first, as the original part does
        mem_addr = ea_reg;
        mem_write = 1'b1;
        mem_wdata = tmp_reg;
        state_next = st_rmw_wr;
      end
      st_rmw_wr: begin
        mem_addr = ea_reg;
        mem_write = 1'b1;
        mem_wdata = sh_res;
        p_next = nz(p_reg, sh_res);
        p_next[`FLAG_C] = sh_c;
        state_next = st_fetch;
      end
      st_push: begin
        mem_addr = stack_addr;
        mem_write = 1'b1;
        mem_wdata = (op_reg == push_accumulator_op) ? a_reg : (p_reg | `PUSH_STATUS_SET);
        sp_next = sp_reg - 8'h01;
        state_next = st_fetch;
      end
      st_pinc: begin
        mem_addr = stack_addr;
        mem_read = 1'b1;
        sp_next = sp_reg + 8'h01;
        state_next = st_pull;
      end
      st_pull: begin
        mem_addr = stack_addr;
        mem_read = 1'b1;
        if (op_reg == pull_accumulator_op) begin
          a_next = mem_rdata;
          p_next = nz(p_reg, mem_rdata);
        end else begin
          p_next = mem_rdata;
        end
        state_next = st_fetch;
      end
      st_jstk: begin
        mem_addr = stack_addr;
        mem_read = 1'b1;
        state_next = st_jpch;
      end
      st_jpch: begin
        // PC now points at the last operand byte
        mem_addr = stack_addr;
        mem_write = 1'b1;
        mem_wdata = pc_reg[15:8];
        sp_next = sp_reg - 8'h01;
        state_next = st_jpcl;
      end
      st_jpcl: begin
        mem_addr = stack_addr;
        mem_write = 1'b1;
        mem_wdata = pc_reg[7:0];
        sp_next = sp_reg - 8'h01;
        state_next = st_jhi;
      end
      st_jhi: begin
        mem_read = 1'b1;
        pc_next = {mem_rdata, tmp_reg};
        state_next = st_fetch;
      end
    endcase
    // Register results; jumps and stack ops never raise exec
    if (exec) begin
      case (op_reg)
        increment_index_x_op: begin
          x_next = inc_x;
          p_next = nz(p_reg, inc_x);
        end
        increment_index_y_op: begin
          y_next = inc_y;
          p_next = nz(p_reg, inc_y);
        end
        load_accumulator_op: begin
          a_next = mem_rdata;
          p_next = nz(p_reg, mem_rdata);
        end
        load_index_x_op: begin
          x_next = mem_rdata;
          p_next = nz(p_reg, mem_rdata);
        end
        load_index_y_op: begin
          y_next = mem_rdata;
          p_next = nz(p_reg, mem_rdata);
        end
        or_accumulator_op: begin
          a_next = a_reg | mem_rdata;
          p_next = nz(p_reg, a_reg | mem_rdata);
        end
        shift_right_op, rotate_left_op: begin
          a_next = sh_res;
          p_next = nz(p_reg, sh_res);
          p_next[`FLAG_C] = sh_c;
        end
        default: begin
          // Idle and unknown codes change nothing
        end
      endcase
    end
  end

  // Core registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= st_fetch;
      op_reg <= idle_op;
      am_reg <= am_imp;
      pc_reg <= RESET_PC;
      ea_reg <= 16'h0000;
      a_reg <= `RESET_BYTE;
      x_reg <= `RESET_BYTE;
      y_reg <= `RESET_BYTE;
      sp_reg <= `RESET_SP;
      p_reg <= `RESET_P;
      tmp_reg <= `RESET_BYTE;
      cross_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      am_reg <= am_next;
      pc_reg <= pc_next;
      ea_reg <= ea_next;
      a_reg <= a_next;
      x_reg <= x_next;
      y_reg <= y_next;
      sp_reg <= sp_next;
      p_reg <= p_next;
      tmp_reg <= tmp_next;
      cross_reg <= cross_next;
    end
  end

  // ==========================================
  // APB slave: zero wait states, read data captured at setup
  always_comb begin
    run_next = run_reg;
    bad_next = bad_reg;
    err_next = err_reg;
    prdata_next = prdata_reg;
    if (psel && !penable) begin
      err_next = 1'b0;
      prdata_next = 32'h00000000;
      case (paddr)
        `ADDR_CTRL: prdata_next = {31'h00000000, run_reg};
        `ADDR_REGS: begin
          prdata_next = {p_reg, y_reg, x_reg, a_reg};
          err_next = pwrite;
        end
        `ADDR_PTRS: begin
          prdata_next = {7'h00, bad_reg, sp_reg, pc_reg};
          err_next = pwrite;
        end
        default: err_next = 1'b1;
      endcase
    end else if (!psel) begin
      err_next = 1'b0;
    end
    if (psel && penable && pwrite && paddr == `ADDR_CTRL) begin
      run_next = pwdata[`CTRL_RUN_BIT];
      if (pwdata[`CTRL_CLR_BIT]) begin
        bad_next = 1'b0;
      end
    end
    // A new unknown opcode beats a clear in the same cycle
    if (bad_set) begin
      bad_next = 1'b1;
    end
  end

  // APB registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_reg <= `CTRL_RUN_RESET;
      bad_reg <= 1'b0;
      err_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      run_reg <= run_next;
      bad_reg <= bad_next;
      err_reg <= err_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = err_reg;

endmodule

// *** test/cpu_core_asserts.sv ***
// Bus and register port checks for the processor core
`include "cpu_core_params.svh"
module cpu_core_asserts #(
  parameter logic [15:0] RESET_PC = 16'h0000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Memory bus
  input wire logic [15:0] mem_addr,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // Register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ========
  // Common timing
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Write on the stack page
  sequence s_stk_wr;
    mem_write && mem_addr[15:8] == `STACK_PAGE;
  endsequence
  // Clearing the run bit
  sequence s_stop;
    psel && penable && pwrite && paddr == `ADDR_CTRL && !pwdata[`CTRL_RUN_BIT];
  endsequence
  // ========
  // Properties
  property p_excl; !(mem_read && mem_write); endproperty
  a_excl: assert property (p_excl) else $error("read and write together");
  property p_wdata; !mem_write |-> mem_wdata == 8'h00; endproperty
  a_wdata: assert property (p_wdata) else $error("write data not idle");
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("register port stalled");
  property p_boot; $rose(reset_n) |-> mem_read && mem_addr == RESET_PC; endproperty
  a_boot: assert property (p_boot) else $error("first fetch not at start address");
  // Two stack writes in a row go downwards
  property p_stk; s_stk_wr ##1 s_stk_wr |-> mem_addr[7:0] == $past(mem_addr[7:0]) - 8'h01; endproperty
  a_stk: assert property (p_stk) else $error("stack writes out of order");
  // Current instruction may take up to seven cycles
  property p_stop; s_stop |-> ##[1:8] !mem_read && !mem_write; endproperty
  a_stop: assert property (p_stop) else $error("core did not halt");
  property p_ctrl; s_stop ##2 (psel && !penable && !pwrite && paddr == `ADDR_CTRL) |=> !prdata[0] && !pslverr;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("run bit readback wrong");
  property p_unmap; psel && !penable && paddr == 12'h00c |=> pslverr && prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
  property p_rowr; psel && !penable && pwrite && paddr == `ADDR_REGS |=> pslverr; endproperty
  a_rowr: assert property (p_rowr) else $error("read-only write not refused");
endmodule

bind cpu_core cpu_core_asserts #(.RESET_PC(RESET_PC)) i_chk (.clk(clk), .reset_n(reset_n), .mem_addr(mem_addr),
  .mem_read(mem_read), .mem_write(mem_write), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));

// *** test/sys_memory.sv ***
// Behavioural system memory on the far side of the core's bus
module sys_memory (
  // Clock
  input wire logic clk,
  // Bus from the core
  input wire logic [15:0] mem_addr,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ========
  // Storage, preloaded by the bench
  logic [7:0] mem [0:65535];
  // Last value shown on the data lines
  logic [7:0] last_q = 8'h00;
  // Asynchronous read; idle lines flip so stale data is never trusted
  assign mem_rdata = mem_read ? mem[mem_addr] : ~last_q;
  // Writes land at the edge ending the cycle
  always @(posedge clk) begin
    last_q <= mem_rdata;
    if (mem_write) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule

// *** test/tb_cpu_core.sv ***
// Self-checking bench for the processor core subset
`include "cpu_core_params.svh"
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin n_errors++; $display("mismatch %0t %s", $time, m); end end
module tb_cpu_core;
  timeunit 1ns;
  timeprecision 1ns;
  // ========
  // Signals
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] mem_addr;
  logic mem_read, mem_write;
  logic [7:0] mem_wdata, mem_rdata;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  // Last register port answer
  logic [31:0] rd;
  logic er;
  int n_errors = 0;
  int cmp_count = 0;
  // 50 ns period
  always #25 clk = ~clk;
  cpu_core i_dut (.clk, .reset_n, .mem_addr, .mem_read, .mem_write, .mem_wdata, .mem_rdata,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  sys_memory i_mem (.clk, .mem_addr, .mem_read, .mem_write, .mem_wdata, .mem_rdata);
  // ========
  // Shared tasks
  task automatic put(input logic [15:0] a, input logic [7:0] b[$]);
    foreach (b[i]) i_mem.mem[a + i] = b[i];
  endtask
  // One register port transfer, held until ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reset the core, blank memory, park a jump-to-self at 0f00
  task automatic start();
    @(posedge clk);
    reset_n <= 1'b0;
    for (int i = 0; i < 65536; i++) i_mem.mem[i] = 8'h00;
    put(16'h0f00, '{8'h4c, 8'h00, 8'h0f});
  endtask
  // Release reset and count cycles until the parked address is fetched
  task automatic go(input int t);
    int n;
    n = 0;
    @(posedge clk);
    reset_n <= 1'b1;
    while (n < 200 && !(mem_read === 1'b1 && mem_addr === 16'h0f00)) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(n, t, "cycle count")
  endtask
  // Compare P Y X A and the stack pointer
  task automatic regs(input logic [31:0] r, input logic [7:0] sp);
    apb(1'b0, `ADDR_REGS, 32'h0);
    `CHK(rd, r, "registers")
    apb(1'b0, `ADDR_PTRS, 32'h0);
    `CHK(rd[23:16], sp, "stack pointer")
  endtask
  // ========
  // Scenarios
  task automatic t_incr();
    start();
    put(16'h0000, '{8'ha2, 8'hff, 8'he8, 8'ha0, 8'h7f, 8'hc8, 8'hea, 8'h4c, 8'h00, 8'h0f});
    go(13);
    regs(32'ha0800000, 8'hff);
  endtask
  // Crossings on BD and BE, none on B9 and BC; BE's wrong page holds ff
  task automatic t_page();
    start();
    put(16'h0000, '{8'ha2, 8'h01, 8'hbd, 8'hff, 8'h10, 8'ha0, 8'h02, 8'hb9, 8'h00, 8'h20});
    put(16'h000a, '{8'hbc, 8'hfe, 8'h30, 8'hbe, 8'hfc, 8'h40, 8'h4c, 8'h00, 8'h0f});
    put(16'h1100, '{8'h55});
    put(16'h2002, '{8'h81});
    put(16'h30ff, '{8'h04});
    put(16'h4000, '{8'hff});
    go(25);
    regs(32'h22040081, 8'hff);
  endtask
  // Indirect-indexed crossing and a zero-page wrap
  task automatic t_or();
    start();
    put(16'h0000, '{8'ha0, 8'h10, 8'h11, 8'h40, 8'h09, 8'h80, 8'ha2, 8'h45, 8'h15, 8'hfe, 8'h4c, 8'h00, 8'h0f});
    put(16'h0040, '{8'hf8, 8'h12});
    put(16'h1308, '{8'h01});
    put(16'h1208, '{8'hff});
    put(16'h0043, '{8'h02});
    put(16'h0143, '{8'hff});
    go(19);
    regs(32'ha0104583, 8'hff);
  endtask
  task automatic t_shift();
    start();
    put(16'h0000, '{8'ha9, 8'h81, 8'h4a, 8'h2a, 8'h46, 8'h50, 8'h3e, 8'h00, 8'h60, 8'h4c, 8'h00, 8'h0f});
    put(16'h0050, '{8'h01});
    put(16'h6000, '{8'h80});
    go(21);
    regs(32'h21000081, 8'hff);
    `CHK(i_mem.mem[16'h0050], 8'h00, "shifted byte")
    `CHK(i_mem.mem[16'h6000], 8'h01, "rotated byte")
  endtask
  task automatic t_stack();
    start();
    put(16'h0000, '{8'ha9, 8'hc3, 8'h48, 8'h08, 8'ha9, 8'h00, 8'h28, 8'h68, 8'h4c, 8'h00, 8'h0f});
    go(21);
    regs(32'hb00000c3, 8'hff);
    `CHK(i_mem.mem[16'h01ff], 8'hc3, "pushed accumulator")
    `CHK(i_mem.mem[16'h01fe], 8'hb0, "pushed status")
  endtask
  task automatic t_jump();
    start();
    put(16'h0000, '{8'h20, 8'h00, 8'h05});
    put(16'h0500, '{8'h6c, 8'h00, 8'h07});
    put(16'h0700, '{8'h00, 8'h06});
    put(16'h0600, '{8'h02, 8'h4c, 8'h00, 8'h0f});
    go(16);
    regs(32'h20000000, 8'hfd);
    `CHK(i_mem.mem[16'h01ff], 8'h00, "return high")
    `CHK(i_mem.mem[16'h01fe], 8'h02, "return low")
  endtask
  // Run control and refused accesses
  task automatic t_apb();
    apb(1'b0, `ADDR_CTRL, 32'h0);
    `CHK(rd[0], 1'b1, "run after reset")
    apb(1'b0, `ADDR_PTRS, 32'h0);
    `CHK(rd[24], 1'b1, "bad flag")
    apb(1'b1, `ADDR_CTRL, 32'h2);
    apb(1'b0, `ADDR_CTRL, 32'h0);
    `CHK(rd[0], 1'b0, "run cleared")
    apb(1'b0, `ADDR_PTRS, 32'h0);
    `CHK(rd[24:0], 25'h0fd0f00, "halted ptrs")
    apb(1'b0, 12'h00c, 32'h0);
    `CHK(er, 1'b1, "unmapped read")
    `CHK(rd, 32'h0, "unmapped data")
    apb(1'b1, `ADDR_REGS, 32'hffffffff);
    `CHK(er, 1'b1, "read-only write")
  endtask
  // ========
  // Verdict
  task automatic test_done();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Main sequence, reset held twelve cycles first
  initial begin
    repeat (12) @(posedge clk);
    t_incr();
    t_page();
    t_or();
    t_shift();
    t_stack();
    t_jump();
    t_apb();
    test_done();
  end
  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #1000000;
    n_errors++;
    test_done();
  end
endmodule
